// [hw/fault_latch_pkg.sv]
// Package with timing constants, state encoding and a carrier struct.
// Summary of operation
// R1 - Stay off until enable pin level reaches its threshold, then start.
// R2 - Feedback low for 500 us uninterrupted forces output low, latched.
// R3 - Undervoltage trip latching drives the fault latch flag low.
// R4 - Undervoltage trip acts only with enable high and ramp above 1.4 V.
// R5 - Feedback high for 500 us uninterrupted forces output low, latched.
// R6 - Overvoltage trip acts only with enable high and ramp above 1.4 V.
// R7 - Supply lockout puts the device in standby; comparator holds hysteresis.
// R8 - Timing pin fault detection is armed always from power-up.
// R9 - Timing pin open or short for 500 us forces output low, latched.
// R10 - Ramp not past threshold within 64 ms of soft start enters off latch.
// R11 - Any confirmed protection enters one common off-latch state.
// R12 - Off latch clears only when enable is taken low once.
// R13 - Thermal trip forces converter output low while it lasts.
// R14 - High-side current limit is checked once in each switching period; the code checks it on every clock.
// R15 - Overcurrent persisting 500 us forces output low, latched.
// R16 - Fault latch flag pin shows off-latch state as a reset output.
// R17 - Qualification timers restart from zero when their condition clears.
// R18 - All intervals counted from the free-running clock, counters sized.
package fault_latch_pkg;

  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned QUAL_US     = 500;
  localparam int unsigned SS_MS       = 64;
  // Least times round down to whole cycles.
  localparam int unsigned QUAL_CYC    =
    (QUAL_US * (CLK_HZ / 1_000_000));
  localparam int unsigned SS_CYC      =
    (SS_MS * (CLK_HZ / 1_000));
  localparam int unsigned QUAL_W      = $clog2(QUAL_CYC + 1);
  localparam int unsigned SS_W        = $clog2(SS_CYC + 1);
  localparam int unsigned NUM_QUAL    = 4;
  localparam int unsigned IDX_UV      = 0;
  localparam int unsigned IDX_OV      = 1;
  localparam int unsigned IDX_TP      = 2;
  localparam int unsigned IDX_OC      = 3;

  typedef enum logic [3:0] {
    ST_STANDBY = 4'h1,
    ST_START   = 4'h2,
    ST_RUN     = 4'h4,
    ST_LATCH   = 4'h8
  } state_e;

  // Comparator results from the analog core.
  typedef struct packed {
    logic enable_pin_level;
    logic supply_lockout;
    logic fb_under;
    logic fb_over;
    logic ramp_above_qual;
    logic ramp_threshold;
    logic timing_pin_fault;
    logic hs_overcurrent;
    logic thermal_trip;
  } sense_s;

endpackage

// [hw/converter_fault_latch_controller.sv]
// Fault qualification and off-latch control for a step-down converter.
module converter_fault_latch_controller (
  input  wire logic                    ref_clk_in,
  input  wire logic                    sys_rst_in,
  input  wire fault_latch_pkg::sense_s sense_in,
  input  wire logic                    period_start_in,
  output logic                         converter_run_out,
  output logic                         hs_gate_allow_out,
  output logic                         fault_latch_flag_n_out,
  output logic [3:0]                   fault_cause_out
);

  // Two-flop synchroniser for all analog comparator inputs.
  fault_latch_pkg::sense_s meta_q, meta_d, sync_q, sync_d;
  logic                    per_meta_q, per_meta_d, per_q, per_d;

  always_comb begin
    meta_d     = sense_in;
    sync_d     = meta_q;
    per_meta_d = period_start_in;
    per_d      = per_meta_q;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_q     <= '0;
      sync_q     <= '0;
      per_meta_q <= 1'b0;
      per_q      <= 1'b0;
    end else begin
      meta_q     <= meta_d;
      sync_q     <= sync_d;
      per_meta_q <= per_meta_d;
      per_q      <= per_d;
    end
  end

  // Step a qualification counter; it saturates at the terminal count.
  function automatic logic [fault_latch_pkg::QUAL_W-1:0] qual_step(
    input logic                              cond,
    input logic [fault_latch_pkg::QUAL_W-1:0] cnt
  );
    logic [fault_latch_pkg::QUAL_W-1:0] res;
    res = '0;
    if (!cond) begin
      res = '0; // R17
    end else if (cnt <
                 fault_latch_pkg::QUAL_W'(fault_latch_pkg::QUAL_CYC)) begin
      res = cnt + 1'b1; // R18
    end else begin
      res = cnt;
    end
    return res;
  endfunction

  fault_latch_pkg::state_e          state_q, state_d;
  logic [fault_latch_pkg::QUAL_W-1:0] qcnt_q [fault_latch_pkg::NUM_QUAL];
  logic [fault_latch_pkg::QUAL_W-1:0] qcnt_d [fault_latch_pkg::NUM_QUAL];
  logic [fault_latch_pkg::SS_W-1:0] ss_cnt_q, ss_cnt_d;
  logic [3:0]                       cause_q, cause_d;
  logic                             run_q, run_d;
  logic                             gate_q, gate_d;
  logic                             flag_n_q, flag_n_d;
  logic [3:0]                       cond;
  logic [3:0]                       done;
  logic                             fb_qual;
  logic                             ss_timeout;

  // Feedback window trips are qualified once the ramp is past 1.4 V,
  // late soft start included, so a dead output cannot hide behind the ramp.
  always_comb begin
    fb_qual = sync_q.enable_pin_level && sync_q.ramp_above_qual &&
              (state_q == fault_latch_pkg::ST_RUN ||
               state_q == fault_latch_pkg::ST_START); // R4 R6
    cond[fault_latch_pkg::IDX_UV] = fb_qual && sync_q.fb_under; // R2 R4
    cond[fault_latch_pkg::IDX_OV] = fb_qual && sync_q.fb_over;  // R5 R6
    cond[fault_latch_pkg::IDX_TP] = sync_q.timing_pin_fault;    // R8
    cond[fault_latch_pkg::IDX_OC] = sync_q.hs_overcurrent &&
      (state_q == fault_latch_pkg::ST_RUN ||
       state_q == fault_latch_pkg::ST_START);                   // R15
    for (int i = 0; i < fault_latch_pkg::NUM_QUAL; i++) begin
      qcnt_d[i] = qual_step(cond[i], qcnt_q[i]);
      done[i]   = (qcnt_q[i] ==
                   fault_latch_pkg::QUAL_W'(fault_latch_pkg::QUAL_CYC));
    end
    ss_timeout = (ss_cnt_q ==
                  fault_latch_pkg::SS_W'(fault_latch_pkg::SS_CYC)); // R10
  end

  // Main sequencer: standby, soft start, run and the common off latch.
  always_comb begin
    state_d  = state_q;
    ss_cnt_d = '0;
    cause_d  = cause_q;
    case (state_q)
      fault_latch_pkg::ST_STANDBY: begin
        cause_d = '0;
        if (sync_q.enable_pin_level && !sync_q.supply_lockout) begin
          state_d = fault_latch_pkg::ST_START; // R1
        end
      end
      fault_latch_pkg::ST_START: begin
        if (ss_cnt_q < fault_latch_pkg::SS_W'(fault_latch_pkg::SS_CYC)) begin
          ss_cnt_d = ss_cnt_q + 1'b1; // R18
        end else begin
          ss_cnt_d = ss_cnt_q;
        end
        if (sync_q.ramp_threshold) begin
          state_d = fault_latch_pkg::ST_RUN;
        end
      end
      fault_latch_pkg::ST_RUN: begin
      end
      fault_latch_pkg::ST_LATCH: begin
        if (!sync_q.enable_pin_level) begin
          state_d = fault_latch_pkg::ST_STANDBY; // R12
        end
      end
      default: begin
        state_d = fault_latch_pkg::ST_STANDBY;
      end
    endcase
    // Any confirmed fault wins over soft start progress.
    if (state_q != fault_latch_pkg::ST_LATCH &&
        (|done || (state_q == fault_latch_pkg::ST_START && ss_timeout))) begin
      state_d = fault_latch_pkg::ST_LATCH; // R11
      cause_d = done;
    end
    // Lockout and enable low return to standby unless latched or latching now,
    // because only enable low may release the latch.
    if (state_q != fault_latch_pkg::ST_LATCH && state_d !=
        fault_latch_pkg::ST_LATCH &&
        (sync_q.supply_lockout || !sync_q.enable_pin_level)) begin
      state_d = fault_latch_pkg::ST_STANDBY; // R7 R1
    end
  end

  // Output drive: run only when operating, flag low while latched.
  always_comb begin
    run_d = (state_d == fault_latch_pkg::ST_START ||
             state_d == fault_latch_pkg::ST_RUN) &&
            !sync_q.thermal_trip; // R13 R2 R5 R9 R15
    // Current limit checked on every clock; after a trip the gate stays off
    // for the rest of that period so a single spike cannot re-arm it.
    if (!run_d || sync_q.hs_overcurrent) begin
      gate_d = 1'b0; // R14
    end else if (per_q) begin
      gate_d = 1'b1; // R14
    end else begin
      gate_d = gate_q;
    end
    flag_n_d = (state_d != fault_latch_pkg::ST_LATCH); // R3 R16
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q  <= fault_latch_pkg::ST_STANDBY;
      ss_cnt_q <= '0;
      cause_q  <= '0;
      run_q    <= 1'b0;
      gate_q   <= 1'b0;
      flag_n_q <= 1'b1;
      for (int i = 0; i < fault_latch_pkg::NUM_QUAL; i++) begin
        qcnt_q[i] <= '0;
      end
    end else begin
      state_q  <= state_d;
      ss_cnt_q <= ss_cnt_d;
      cause_q  <= cause_d;
      run_q    <= run_d;
      gate_q   <= gate_d;
      flag_n_q <= flag_n_d;
      for (int i = 0; i < fault_latch_pkg::NUM_QUAL; i++) begin
        qcnt_q[i] <= qcnt_d[i];
      end
    end
  end

  assign converter_run_out      = run_q;
  assign hs_gate_allow_out      = gate_q;
  assign fault_latch_flag_n_out = flag_n_q;
  assign fault_cause_out        = cause_q;

  // Checks on qualification, latch, thermal and lockout behaviour.
  sequence s_latched;
    state_q == fault_latch_pkg::ST_LATCH;
  endsequence

  chk_latch_flag_low: assert property ( // R3
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    s_latched |-> !fault_latch_flag_n_out && !converter_run_out)
    else $error("Flag or output wrong while latched.");

  chk_latch_holds_enable: assert property ( // R12
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    state_q == fault_latch_pkg::ST_LATCH &&
    sync_q.enable_pin_level |=> s_latched)
    else $error("Latch left with enable high.");

  chk_uv_qual_time: assert property ( // R2
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    $rose(done[fault_latch_pkg::IDX_UV]) |-> $past(cond[0], 4999))
    else $error("Undervoltage confirmed too early.");

  chk_uv_gated: assert property ( // R4
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    !sync_q.ramp_above_qual |-> qcnt_d[fault_latch_pkg::IDX_UV] == '0)
    else $error("Undervoltage counted below ramp level.");

  chk_ov_gated: assert property ( // R6
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    !sync_q.enable_pin_level |-> qcnt_d[fault_latch_pkg::IDX_OV] == '0)
    else $error("Overvoltage counted with enable low.");

  chk_qual_restart: assert property ( // R17
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    !cond[fault_latch_pkg::IDX_TP] |=> qcnt_q[fault_latch_pkg::IDX_TP] == '0)
    else $error("Timer did not restart.");

  chk_fault_enters_latch: assert property ( // R11
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    |done && state_q != fault_latch_pkg::ST_LATCH |=> s_latched)
    else $error("Confirmed fault did not latch.");

  chk_ss_timeout_latch: assert property ( // R10
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    state_q == fault_latch_pkg::ST_START && ss_timeout |=> s_latched)
    else $error("Soft start timeout did not latch.");

  chk_thermal_off: assert property ( // R13
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    sync_q.thermal_trip |=> !converter_run_out)
    else $error("Output ran during thermal trip.");

  chk_lockout_standby: assert property ( // R7
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    sync_q.supply_lockout && state_q != fault_latch_pkg::ST_LATCH |=>
    !converter_run_out)
    else $error("Output ran in lockout.");

endmodule

// [verification/converter_stage_model.sv]
// Behavioural soft-start ramp and switching period source.
module converter_stage_model (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic run_in,
  input  wire logic ramp_hold_in,
  output logic      ramp_above_qual_out,
  output logic      ramp_threshold_out,
  output logic      period_start_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned ramp_q;
  int unsigned per_q;
  // The ramp discharges whenever the converter stops, as the cap would.
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ramp_q <= 0;
      per_q  <= 0;
    end else begin
      per_q <= (per_q == 15) ? 0 : per_q + 1;
      if (!run_in || ramp_hold_in) begin
        ramp_q <= 0;
      end else if (ramp_q < 60) begin
        ramp_q <= ramp_q + 1;
      end
    end
  end
  // Short ramp keeps the run brief; real soft start is far slower.
  assign ramp_above_qual_out = (ramp_q >= 20);
  assign ramp_threshold_out  = (ramp_q >= 40);
  assign period_start_out    = (per_q == 0);
endmodule

// [verification/converter_fault_latch_controller_test.sv]
// Self-checking bench for the fault latch controller.
module converter_fault_latch_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    ref_clk_in;
  logic                    sys_rst_in;
  logic                    en;
  logic                    lock;
  logic                    th;
  logic                    hold;
  logic [3:0]              flt;
  logic                    aq;
  logic                    rt;
  logic                    ps;
  logic                    run;
  logic                    gate;
  logic                    flag_n;
  logic [3:0]              cause;
  fault_latch_pkg::sense_s sense;
  int                      miscompares;
  int                      checks_done;
  // Upper nibble is the fault applied, lower nibble the cause expected.
  logic [7:0]              rows [4] = '{8'h11, 8'h22, 8'h44, 8'h88};

  assign sense = {en, lock, flt[0], flt[1], aq, rt, flt[2], flt[3], th};

  converter_stage_model u_model (
    .ref_clk_in          (ref_clk_in),
    .sys_rst_in          (sys_rst_in),
    .run_in              (run),
    .ramp_hold_in        (hold),
    .ramp_above_qual_out (aq),
    .ramp_threshold_out  (rt),
    .period_start_out    (ps)
  );

  converter_fault_latch_controller u_dut (
    .ref_clk_in             (ref_clk_in),
    .sys_rst_in             (sys_rst_in),
    .sense_in               (sense),
    .period_start_in        (ps),
    .converter_run_out      (run),
    .hs_gate_allow_out      (gate),
    .fault_latch_flag_n_out (flag_n),
    .fault_cause_out        (cause)
  );

  always #50 ref_clk_in = ~ref_clk_in;

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  // Bounded wait, so a flag that never moves cannot hang the run.
  task automatic wait_flag(input logic v, input int n);
    int i;
    for (i = 0; i < n && flag_n !== v; i++) @(negedge ref_clk_in);
  endtask

  // Enable goes low once, so any earlier latch is released first.
  task automatic start_up;
    flt = 4'h0;
    en = 1'b0;
    cyc(10);
    en = 1'b1;
    cyc(80);
  endtask

  task automatic finish_test;
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #6_000_000;
    miscompares++;
    finish_test();
  end

  initial begin
    ref_clk_in = 1'b0;
    sys_rst_in = 1'b1;
    {en, lock, th, hold, flt} = 8'h00;
    cyc(3);
    sys_rst_in = 1'b0;
    chk(flag_n, 4'h1);
    cyc(10);
    chk(run, 4'h0);
    foreach (rows[k]) begin
      start_up();
      chk(run, 4'h1);
      flt = rows[k][7:4];
      cyc(4900);
      chk(flag_n, 4'h1);
      wait_flag(1'b0, 300);
      chk(flag_n, 4'h0);
      chk(cause, rows[k][3:0]);
      chk(run, 4'h0);
      flt = 4'h0;
      cyc(100);
      chk(flag_n, 4'h0);
      en = 1'b0;
      wait_flag(1'b1, 10);
      chk(flag_n, 4'h1);
    end
    // An interrupted condition must start its count over.
    start_up();
    flt = 4'h1;
    cyc(4000);
    flt = 4'h0;
    cyc(5);
    flt = 4'h1;
    cyc(4000);
    chk(flag_n, 4'h1);
    // Ramp held low: feedback faults stay disarmed, timing pin does not.
    hold = 1'b1;
    start_up();
    flt = 4'h7;
    wait_flag(1'b0, 5300);
    chk(cause, 4'h4);
    hold = 1'b0;
    start_up();
    chk(gate, 4'h1);
    flt = 4'h8;
    cyc(6);
    chk(gate, 4'h0);
    flt = 4'h0;
    cyc(40);
    chk(gate, 4'h1);
    th = 1'b1;
    cyc(8);
    chk(run, 4'h0);
    chk(flag_n, 4'h1);
    th = 1'b0;
    cyc(10);
    chk(run, 4'h1);
    lock = 1'b1;
    cyc(8);
    chk(run, 4'h0);
    lock = 1'b0;
    cyc(10);
    chk(run, 4'h1);
    sys_rst_in = 1'b1;
    cyc(2);
    chk(run, 4'h0);
    chk(flag_n, 4'h1);
    sys_rst_in = 1'b0;
    cyc(1);
    chk(run, 4'h0);
    cyc(4);
    chk(run, 4'h1);
    finish_test();
  end
endmodule
